// >>> bench/timer_out_init_edge_flags_tb_top.sv
// self-checking testbench for the timer output level and edge flag block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module timer_out_init_edge_flags_tb_top;
  logic mclk, rst_n, we, cyc, stb, ack, dmode, irq, run_req, dlvl;
  logic dmi, srun, lrun, swave, lwave, spin, lpin;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0] subv [4] = '{8'h05, 8'h04, 8'h09, 8'h0D};
  logic subx [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int num_errors = 0;
  int compares = 0;
  tmo_core u_tmo_core (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .demod_in(dmi),
    .short_timer_run(srun), .long_timer_run(lrun), .short_timer_wave(swave), .long_timer_wave(lwave),
    .short_timer_output(spin), .long_timer_output(lpin), .demod_mode(dmode), .irq(irq));
  tmo_far_model u_tmo_far_model (.mclk(mclk), .rst_n(rst_n), .run_req(run_req), .demod_lvl(dlvl),
    .demod_in(dmi), .short_timer_run(srun), .long_timer_run(lrun), .short_timer_wave(swave),
    .long_timer_wave(lwave));
  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  // one classic cycle, held until ack is seen at a rising edge; only the watchdog ends a wait
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0000_0000);
    `CHK(q, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // the tests need about 150 cycles; this bound only catches a hang
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    test_done();
  end
  initial begin
    {rst_n, cyc, stb, we, run_req, dlvl} = 6'h00;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'hF;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    idle(4);
    `CHK({spin, lpin, dmode, irq}, 4'b1100)
    rd(tmo_pkg::ADDR_CTRL, {24'h00_0000, tmo_pkg::CTRL_RST});
    $display("test reset done");
    // select low/high for both pins, idle level first, then the enabling step
    for (logic [2:0] i = 0; i < 4; i++) begin
      wb(tmo_pkg::ADDR_CTRL, 1'b1, {29'h0, i});
      idle(2);
      `CHK({spin, lpin}, ~i[1:0])
      @(posedge mclk);
      run_req <= 1'b1;
      @(posedge mclk);
      #1;
      `CHK({spin, lpin}, i[1:0])
      // from the second running cycle the pins carry the waves sampled at the edge
      q = {30'h0000_0000, swave, lwave};
      @(posedge mclk);
      run_req <= 1'b0;
      #1;
      `CHK({spin, lpin}, q[1:0])
    end
    $display("test select done");
    foreach (subv[k]) begin
      wb(tmo_pkg::ADDR_CTRL, 1'b1, {24'h00_0000, subv[k]});
      idle(2);
      `CHK(lpin, subx[k])
    end
    $display("test submode done");
    wb(tmo_pkg::ADDR_TEN, 1'b1, 32'h0000_0003);
    rd(tmo_pkg::ADDR_TEN, 32'h0000_0003);
    wb(tmo_pkg::ADDR_TEN, 1'b1, 32'h0000_0000);
    wb(8'h14, 1'b1, 32'h0000_00FF);
    rd(8'h14, 32'h0000_0000);
    rd(tmo_pkg::ADDR_ICLR, 32'h0000_0000);
    $display("test registers done");
    // demodulation: sticky flags, write-one-clear, status and interrupt
    wb(tmo_pkg::ADDR_IEN, 1'b1, 32'h0000_0003);
    wb(tmo_pkg::ADDR_CTRL, 1'b1, 32'h0000_0080);
    idle(2);
    `CHK({spin, lpin, dmode, irq}, 4'b0010)
    @(posedge mclk);
    dlvl <= 1'b1;
    idle(4);
    `CHK(irq, 1'b1)
    rd(tmo_pkg::ADDR_CTRL, 32'h0000_0082);
    wb(tmo_pkg::ADDR_CTRL, 1'b1, 32'h0000_0080);
    rd(tmo_pkg::ADDR_CTRL, 32'h0000_0082);
    @(posedge mclk);
    dlvl <= 1'b0;
    idle(4);
    rd(tmo_pkg::ADDR_CTRL, 32'h0000_0083);
    rd(tmo_pkg::ADDR_STAT, 32'h0000_0003);
    wb(tmo_pkg::ADDR_CTRL, 1'b1, 32'h0000_0081);
    rd(tmo_pkg::ADDR_CTRL, 32'h0000_0082);
    wb(tmo_pkg::ADDR_CTRL, 1'b1, 32'h0000_0082);
    rd(tmo_pkg::ADDR_CTRL, 32'h0000_0080);
    wb(tmo_pkg::ADDR_IEN, 1'b1, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wb(tmo_pkg::ADDR_ICLR, 1'b1, 32'h0000_0003);
    rd(tmo_pkg::ADDR_STAT, 32'h0000_0000);
    $display("test demod done");
    test_done();
  end
endmodule

// >>> bench/tmo_far_model.sv
// far-side model: counter enables, counter waveforms and demodulator input
`timescale 1ns/10ps
module tmo_far_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run_req,
  input wire logic demod_lvl,
  output logic demod_in,
  output logic short_timer_run,
  output logic long_timer_run,
  output logic short_timer_wave,
  output logic long_timer_wave
);
  logic tog_q;
  // waveforms flip every cycle so a pin stuck on its select is seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end
  // enables move only while the selects are left alone
  assign short_timer_run = run_req;
  assign long_timer_run = run_req;
  assign short_timer_wave = tog_q;
  assign long_timer_wave = ~tog_q;
  assign demod_in = demod_lvl;
endmodule

// >>> src/tmo_core.sv
// timer output initial levels and demodulator edge flags with wishbone registers
`timescale 1ns/10ps
module tmo_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic demod_in,
  input wire logic short_timer_run,
  input wire logic long_timer_run,
  input wire logic short_timer_wave,
  input wire logic long_timer_wave,
  output logic short_timer_output,
  output logic long_timer_output,
  output logic demod_mode,
  output logic irq
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_loc_n;
  // asynchronous assert, release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_loc_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic lane0;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign lane0 = wb_sel_i[0];

  // ----------------------------------------------------------------
  // control register and edge flags
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] ien_q;
  logic [1:0] ien_d;
  logic [1:0] ist_q;
  logic [1:0] ist_d;
  logic demod_prev_q;
  logic demod_prev_d;
  logic rise_ev;
  logic fall_ev;
  logic mode;
  logic ctrl_wr;
  logic [1:0] flag_clr;
  logic ten_wr;

  assign mode = ctrl_q[tmo_pkg::BIT_MODE];
  assign ctrl_wr = wr && lane0 && (wb_adr_i == tmo_pkg::ADDR_CTRL);
  assign ten_wr = wr && lane0 && (wb_adr_i == tmo_pkg::ADDR_TEN);
  // edges only count in demodulation mode
  assign rise_ev = mode && demod_in && !demod_prev_q;
  assign fall_ev = mode && !demod_in && demod_prev_q;
  // write-one-to-clear applies only while the bits are flags
  assign flag_clr = (ctrl_wr && mode) ? wb_dat_i[1:0] : 2'b00;

  // next values; a set in the clear cycle wins so no edge is lost
  always_comb begin
    ctrl_d = ctrl_q;
    demod_prev_d = demod_in;
    if (ctrl_wr) begin
      ctrl_d[7:2] = wb_dat_i[7:2];
      if (!mode) begin
        ctrl_d[1:0] = wb_dat_i[1:0];
      end
    end
    // a mode change by this write drops the old flags or levels as written
    if (ctrl_wr && (wb_dat_i[tmo_pkg::BIT_MODE] != mode)) begin
      ctrl_d[1:0] = wb_dat_i[tmo_pkg::BIT_MODE] ? 2'b00 : wb_dat_i[1:0];
    end else begin
      if (mode) begin
        ctrl_d[tmo_pkg::BIT_RISE] = rise_ev | (ctrl_q[tmo_pkg::BIT_RISE] & ~flag_clr[1]);
        ctrl_d[tmo_pkg::BIT_FALL] = fall_ev | (ctrl_q[tmo_pkg::BIT_FALL] & ~flag_clr[0]);
      end
    end
  end

  // interrupt status, enable and clear
  always_comb begin
    ien_d = ien_q;
    ist_d = ist_q;
    if (wr && lane0 && (wb_adr_i == tmo_pkg::ADDR_IEN)) begin
      ien_d = wb_dat_i[1:0];
    end
    if (wr && lane0 && (wb_adr_i == tmo_pkg::ADDR_ICLR)) begin
      ist_d = ist_q & ~wb_dat_i[1:0];
    end
    ist_d = ist_d | {rise_ev, fall_ev};
  end

  always_ff @(posedge mclk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      ctrl_q <= tmo_pkg::CTRL_RST;
      ien_q <= tmo_pkg::IRQ_RST;
      ist_q <= tmo_pkg::IRQ_RST;
      demod_prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      demod_prev_q <= demod_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // software timer enables (or-ed with the counter logic's own)
  // ----------------------------------------------------------------
  logic [1:0] ten_q;
  logic [1:0] ten_d;
  always_comb begin
    ten_d = ten_q;
    if (ten_wr) begin
      ten_d = wb_dat_i[1:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      ten_q <= 2'b00;
    end else begin
      ten_q <= ten_d;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  tmo_pkg::tmo_pins_t pins_q;
  tmo_pkg::tmo_pins_t pins_d;
  logic run8;
  logic run16;
  logic run8_q;
  logic run16_q;
  tmo_pkg::tmo_sub_t sub;
  assign run8 = short_timer_run | ten_q[0];
  assign run16 = long_timer_run | ten_q[1];
  assign sub = tmo_pkg::tmo_sub_t'(ctrl_q[3:2]);

  // the first running cycle drives the initial level, then the counter's wave
  always_comb begin
    pins_d = pins_q;
    if (mode) begin
      pins_d.short_timer_output = 1'b0;
      pins_d.long_timer_output = 1'b0;
    end else begin
      if (!run8) begin
        pins_d.short_timer_output = ~ctrl_q[tmo_pkg::BIT_RISE];
      end else if (!run8_q) begin
        pins_d.short_timer_output = ctrl_q[tmo_pkg::BIT_RISE];
      end else begin
        pins_d.short_timer_output = short_timer_wave;
      end
      unique case (sub)
        tmo_pkg::TMO_SUB_FORCE0: pins_d.long_timer_output = 1'b0;
        tmo_pkg::TMO_SUB_FORCE1: pins_d.long_timer_output = 1'b1;
        tmo_pkg::TMO_SUB_NORMAL, tmo_pkg::TMO_SUB_ALT: begin
          if (!run16) begin
            pins_d.long_timer_output = ~ctrl_q[tmo_pkg::BIT_FALL];
          end else if (!run16_q) begin
            pins_d.long_timer_output = ctrl_q[tmo_pkg::BIT_FALL];
          end else begin
            pins_d.long_timer_output = long_timer_wave;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      pins_q <= '{short_timer_output: 1'b1, long_timer_output: 1'b1};
      run8_q <= 1'b0;
      run16_q <= 1'b0;
    end else begin
      pins_q <= pins_d;
      run8_q <= run8;
      run16_q <= run16;
    end
  end

  // ----------------------------------------------------------------
  // read data and acknowledge, registered, so one wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    ack_d = req;
    rdat_d = rdat_q;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        tmo_pkg::ADDR_CTRL: rdat_d = {24'h0000_00, ctrl_q};
        tmo_pkg::ADDR_STAT: rdat_d = {30'h0000_0000, ist_q};
        tmo_pkg::ADDR_IEN: rdat_d = {30'h0000_0000, ien_q};
        tmo_pkg::ADDR_TEN: rdat_d = {30'h0000_0000, ten_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign short_timer_output = pins_q.short_timer_output;
  assign long_timer_output = pins_q.long_timer_output;
  assign demod_mode = mode;
  assign irq = |(ist_q & ien_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // edge flags; a write that leaves demodulation mode reloads bits 1:0, so it is excluded
  a_rise_flag_set: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (mode && !demod_prev_q && demod_in && !(ctrl_wr && !wb_dat_i[7])) |=> ctrl_q[1])
    else $error("rising edge not flagged");
  a_fall_flag_set: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (mode && demod_prev_q && !demod_in && !(ctrl_wr && !wb_dat_i[7])) |=> ctrl_q[0])
    else $error("falling edge not flagged");
  // a set wins over a clear in one cycle, so clears are only checked without an edge
  a_flag_clear_one: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (mode && ctrl_wr && wb_dat_i[7] && wb_dat_i[1] && !rise_ev) |=> !ctrl_q[1])
    else $error("rising flag not cleared");
  a_flag_clear_fall: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (mode && ctrl_wr && wb_dat_i[7] && wb_dat_i[0] && !fall_ev) |=> !ctrl_q[0])
    else $error("falling flag not cleared");
  // writing zero to a flag must leave it alone
  a_flag_hold_zero: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (mode && ctrl_wr && wb_dat_i[7] && !wb_dat_i[0] && ctrl_q[0]) |=> ctrl_q[0])
    else $error("falling flag lost on write of zero");
  a_flag_hold_rise: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (mode && ctrl_wr && wb_dat_i[7] && !wb_dat_i[1] && ctrl_q[1]) |=> ctrl_q[1])
    else $error("rising flag lost on write of zero");
  // status bits follow the same edges, so the interrupt never misses a flag
  a_rise_status: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    rise_ev |=> ist_q[1])
    else $error("rising edge not in status");
  a_fall_status: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    fall_ev |=> ist_q[0])
    else $error("falling edge not in status");
  // transmit pins; a control write in the same cycle moves the select, so it is excluded
  a_idle_short_level: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (!mode && !run8 && !ctrl_wr) |=> short_timer_output == !ctrl_q[1])
    else $error("disabled short output not inverted");
  a_idle_long_level: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (!mode && !ctrl_q[3] && !run16 && !ctrl_wr) |=> long_timer_output == !ctrl_q[0])
    else $error("disabled long output not inverted");
  // the first running cycle shows the select whatever the counter wave does
  a_enable_short_edge: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (!mode && run8 && !run8_q && !ctrl_wr) |=> short_timer_output == ctrl_q[1])
    else $error("short output missed initial level");
  a_enable_long_edge: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (!mode && !ctrl_q[3] && run16 && !run16_q && !ctrl_wr) |=> long_timer_output == ctrl_q[0])
    else $error("long output missed initial level");
  // forced submodes override the run state entirely
  a_force_long: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (!mode && ctrl_q[3] && !ctrl_wr) |=> long_timer_output == ctrl_q[2])
    else $error("long output not forced");
  // select bits load from any write that leaves the block in transmit mode
  a_select_load: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    (!mode && ctrl_wr && !wb_dat_i[7]) |=> ctrl_q[1:0] == $past(wb_dat_i[1:0]))
    else $error("select bits not loaded");
  // demodulation mode parks both pins low
  a_demod_pins_low: assert property (@(posedge mclk) disable iff (!rst_loc_n)
    mode |=> (!short_timer_output && !long_timer_output))
    else $error("pins not low in demodulation mode");
endmodule

// >>> src/tmo_pkg.sv
// package for the timer output initial level and edge flag block
package tmo_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the bus, one word apart)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IEN = 8'h08;
  localparam logic [7:0] ADDR_ICLR = 8'h0C;
  localparam logic [7:0] ADDR_TEN = 8'h10;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_FALL = 0;
  localparam int BIT_RISE = 1;
  localparam int BIT_SUB_LO = 2;
  localparam int BIT_MODE = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // submode codes
  typedef enum logic [1:0] {
    TMO_SUB_NORMAL = 2'b00,
    TMO_SUB_ALT = 2'b01,
    TMO_SUB_FORCE0 = 2'b10,
    TMO_SUB_FORCE1 = 2'b11
  } tmo_sub_t;
  // pin group carried to the output stage
  typedef struct packed {
    logic short_timer_output;
    logic long_timer_output;
  } tmo_pins_t;
endpackage
